// file: rtl/tbspp_port.sv
`include "tbspp_consts.svh"

// Contract
// - two separate sixteen-byte queues, one for received and one for outgoing bytes
// - receive on every header; drive outgoing data only at the master header
// - every packet starts with start marker byte 0x82
// - marker, then command buffer, then exactly two check bytes
// - buffer holds command, length 0 to 60, then data bytes
// - command 0 is echo; receiver returns packet unchanged, no acknowledge
// - command 1 with one byte switches the per-second stamp report on or off
// - command 2 has five bytes: clock source, then rate in hertz LSB first
// - command 3 from controller carries 4 to 8 seconds bytes, LSB first
// - check bytes cover command, length and data, not the marker
// - low check inverts XOR of odd bytes, high inverts XOR of even
// - data register reads receive head, write pushes to transmit queue
// - status bit 7 reads one when attached at the master header
// - status bit 6 set once the recovered IRIG second pulse is seen
// - status bit 5 set once the satellite receiver second pulse is seen
// - status bit 4 always reads zero
// - bit 3 shows transmit queue empty, bit 2 transmit queue full
// - bit 1 shows receive queue empty
// - toggling bit 0 resets the data path; reading bit 0 shows overflow
// - any write to the strobe register advances the receive queue
module tbspp_port #(
  parameter int DEPTH = `TBSPP_QUEUE_DEPTH
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // avalon-mm slave
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // serial link, clock and data from the controller
  input wire logic link_clk_i,
  input wire logic link_rx_i,
  output logic link_tx_o,
  output logic link_tx_oe_n_o,
  // board pins
  input wire logic master_header_i,
  input wire logic irig_pps_i,
  input wire logic gps_pps_i
);
  localparam int CW = $clog2(DEPTH) + 1;

  // ===========================================================
  // pin synchronisers
  logic [4:0] pins_s;
  logic sclk_s;
  logic mosi_s;
  logic master_s;
  logic irig_s;
  logic gps_s;
  logic sclk_d_reg;
  logic irig_d_reg;
  logic gps_d_reg;
  logic sclk_rise;
  logic sclk_fall;

  tbspp_sync #(.WIDTH(5)) u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .async_i({link_clk_i, link_rx_i, master_header_i, irig_pps_i, gps_pps_i}),
    .sync_o(pins_s)
  );
  assign {sclk_s, mosi_s, master_s, irig_s, gps_s} = pins_s;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_d_reg <= 1'b0;
      irig_d_reg <= 1'b0;
      gps_d_reg <= 1'b0;
    end else begin
      sclk_d_reg <= sclk_s;
      irig_d_reg <= irig_s;
      gps_d_reg <= gps_s;
    end
  end
  // device samples the controller's clock, never makes it
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;

  // ===========================================================
  // bus slave: one wait cycle, then one answer cycle
  logic [7:0] idx;
  logic req;
  logic acc;
  logic wr_acc;
  logic wr_data;
  logic wr_stat;
  logic wr_strobe;
  logic dp_flush;
  logic toggle_reg;
  logic [7:0] rd_val;

  assign idx = avs_address_i[9:2];
  assign req = avs_read_i || avs_write_i;
  assign acc = req && !avs_waitrequest_o;
  assign wr_acc = acc && avs_write_i && avs_byteenable_i[0];
  assign wr_data = wr_acc && (idx == `TBSPP_IDX_DATA);
  assign wr_stat = wr_acc && (idx == `TBSPP_IDX_STAT);
  assign wr_strobe = wr_acc && (idx == `TBSPP_IDX_STROBE);
  // a change of the written bit 0 flushes the whole serial path
  assign dp_flush = wr_stat && (avs_writedata_i[`TBSPP_ST_OVF] != toggle_reg);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      avs_waitrequest_o <= !(req && avs_waitrequest_o);
      if (avs_read_i && avs_waitrequest_o) begin
        avs_readdata_o <= {24'h00_0000, rd_val};
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      toggle_reg <= 1'b0;
    end else if (wr_stat) begin
      toggle_reg <= avs_writedata_i[`TBSPP_ST_OVF];
    end
  end

  // ===========================================================
  // queues
  logic rx_push;
  logic rx_full;
  logic rx_empty;
  logic [7:0] rx_head;
  logic [CW-1:0] rx_count;
  logic tx_pop;
  logic tx_full;
  logic tx_empty;
  logic [7:0] tx_head;
  logic [CW-1:0] tx_count;
  logic [7:0] rx_shift_reg;
  logic [7:0] rx_byte;
  logic [2:0] bit_cnt_reg;

  // two independent queues, one per direction
  // every received byte, echo and answers included, reaches software unless the receive queue is full
  tbspp_queue #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(dp_flush),
    .push_i(rx_push),
    .din_i(rx_byte),
    .full_o(rx_full),
    .pop_i(wr_strobe),
    .head_o(rx_head),
    .empty_o(rx_empty),
    .count_o(rx_count)
  );

  // queue refuses pushes when full and pops when empty
  tbspp_queue #(.WIDTH(8), .DEPTH(DEPTH)) u_tx_queue (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .flush_i(dp_flush),
    .push_i(wr_data),
    .din_i(avs_writedata_i[7:0]),
    .full_o(tx_full),
    .pop_i(tx_pop),
    .head_o(tx_head),
    .empty_o(tx_empty),
    .count_o(tx_count)
  );

  // ===========================================================
  // link receive, msb first, byte complete on the eighth rising edge
  assign rx_byte = {rx_shift_reg[6:0], mosi_s};
  assign rx_push = sclk_rise && (bit_cnt_reg == `TBSPP_BITS_PER_BYTE) && !dp_flush;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (dp_flush) begin
      rx_shift_reg <= 8'h00;
      bit_cnt_reg <= 3'h0;
    end else if (sclk_rise) begin
      rx_shift_reg <= rx_byte;
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
    end
  end

  // ===========================================================
  // link transmit: next bit is set up on each falling edge
  logic [7:0] tx_byte_reg;
  logic tx_valid_reg;

  // load only while idle between bytes and only at the master header
  assign tx_pop = (bit_cnt_reg == 3'h0) && !tx_valid_reg && !tx_empty && master_s
    && !sclk_rise && !dp_flush;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_byte_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      link_tx_o <= 1'b0;
    end else if (dp_flush) begin
      tx_byte_reg <= 8'h00;
      tx_valid_reg <= 1'b0;
      link_tx_o <= 1'b0;
    end else if (tx_pop) begin
      tx_byte_reg <= tx_head;
      tx_valid_reg <= 1'b1;
      link_tx_o <= tx_head[7];
    end else begin
      if (rx_push) begin
        tx_valid_reg <= 1'b0;
      end
      if (sclk_fall) begin
        link_tx_o <= tx_valid_reg && tx_byte_reg[3'h7 - bit_cnt_reg];
      end
    end
  end

  // pin is released away from the master header
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      link_tx_oe_n_o <= 1'b1;
    end else begin
      link_tx_oe_n_o <= !master_s;
    end
  end

  // ===========================================================
  // sticky status flags; a new event wins over the flush
  logic ovf_reg;
  logic irig_seen_reg;
  logic gps_seen_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ovf_reg <= 1'b0;
      irig_seen_reg <= 1'b0;
      gps_seen_reg <= 1'b0;
    end else begin
      // overflow means the byte was lost; software must drain in time
      if (sclk_rise && (bit_cnt_reg == `TBSPP_BITS_PER_BYTE) && rx_full) begin
        ovf_reg <= 1'b1;
      end else if (dp_flush) begin
        ovf_reg <= 1'b0;
      end
      if (irig_s && !irig_d_reg) begin
        irig_seen_reg <= 1'b1;
      end else if (dp_flush) begin
        irig_seen_reg <= 1'b0;
      end
      if (gps_s && !gps_d_reg) begin
        gps_seen_reg <= 1'b1;
      end else if (dp_flush) begin
        gps_seen_reg <= 1'b0;
      end
    end
  end

  // ===========================================================
  // receive packet walker, catches seconds reports
  tbspp_pkg::tbspp_state_t state_reg;
  logic [7:0] cmd_reg;
  logic [7:0] len_reg;
  logic [7:0] left_reg;
  logic [7:0] xor_odd_reg;
  logic [7:0] xor_even_reg;
  logic odd_pos_reg;
  logic [7:0] shadow_reg [8];
  logic [7:0] stamp_reg [8];
  logic stamp_new_reg;
  logic ckerr_reg;
  logic stamp_take;
  logic stamp_ok;

  // marker and check bytes stay out of the running xor
  assign stamp_ok = (cmd_reg == `TBSPP_CMD_STAMP) && (len_reg >= `TBSPP_STAMP_MIN)
    && (len_reg <= `TBSPP_STAMP_MAX);
  assign stamp_take = rx_push && (state_reg == tbspp_pkg::TBSPP_CKH) && stamp_ok
    && (rx_byte == ~xor_even_reg);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_reg <= tbspp_pkg::TBSPP_IDLE;
      cmd_reg <= 8'h00;
      len_reg <= 8'h00;
      left_reg <= 8'h00;
      xor_odd_reg <= 8'h00;
      xor_even_reg <= 8'h00;
      odd_pos_reg <= 1'b1;
      ckerr_reg <= 1'b0;
    end else if (dp_flush) begin
      state_reg <= tbspp_pkg::TBSPP_IDLE;
      ckerr_reg <= 1'b0;
    end else if (rx_push) begin
      case (state_reg)
        tbspp_pkg::TBSPP_IDLE: begin
          xor_odd_reg <= 8'h00;
          xor_even_reg <= 8'h00;
          odd_pos_reg <= 1'b1;
          if (rx_byte == `TBSPP_FRAME_START) begin
            state_reg <= tbspp_pkg::TBSPP_CMD;
          end
        end
        tbspp_pkg::TBSPP_CMD: begin
          cmd_reg <= rx_byte;
          xor_odd_reg <= rx_byte;
          odd_pos_reg <= 1'b0;
          state_reg <= tbspp_pkg::TBSPP_LEN;
        end
        tbspp_pkg::TBSPP_LEN: begin
          len_reg <= rx_byte;
          left_reg <= rx_byte;
          xor_even_reg <= rx_byte;
          odd_pos_reg <= 1'b1;
          if (rx_byte > `TBSPP_LEN_MAX) begin
            state_reg <= tbspp_pkg::TBSPP_IDLE;
          end else if (rx_byte == 8'h00) begin
            state_reg <= tbspp_pkg::TBSPP_CKL;
          end else begin
            state_reg <= tbspp_pkg::TBSPP_DATA;
          end
        end
        tbspp_pkg::TBSPP_DATA: begin
          if (odd_pos_reg) begin
            xor_odd_reg <= xor_odd_reg ^ rx_byte;
          end else begin
            xor_even_reg <= xor_even_reg ^ rx_byte;
          end
          odd_pos_reg <= !odd_pos_reg;
          left_reg <= left_reg - 8'h01;
          if (left_reg == 8'h01) begin
            state_reg <= tbspp_pkg::TBSPP_CKL;
          end
        end
        tbspp_pkg::TBSPP_CKL: begin
          if (rx_byte != ~xor_odd_reg) begin
            ckerr_reg <= 1'b1;
            state_reg <= tbspp_pkg::TBSPP_IDLE;
          end else begin
            state_reg <= tbspp_pkg::TBSPP_CKH;
          end
        end
        tbspp_pkg::TBSPP_CKH: begin
          if (rx_byte != ~xor_even_reg) begin
            ckerr_reg <= 1'b1;
          end
          state_reg <= tbspp_pkg::TBSPP_IDLE;
        end
        default: begin
          state_reg <= tbspp_pkg::TBSPP_IDLE;
        end
      endcase
    end
  end

  // data bytes land lsb first; bytes past the eighth are not kept
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        shadow_reg[i] <= 8'h00;
        stamp_reg[i] <= 8'h00;
      end
      stamp_new_reg <= 1'b0;
    end else begin
      if (rx_push && (state_reg == tbspp_pkg::TBSPP_LEN)) begin
        for (int i = 0; i < 8; i++) begin
          shadow_reg[i] <= 8'h00;
        end
      end else if (rx_push && (state_reg == tbspp_pkg::TBSPP_DATA)
        && ((len_reg - left_reg) < 8'h08)) begin
        shadow_reg[3'((len_reg - left_reg))] <= rx_byte;
      end
      if (stamp_take) begin
        stamp_reg <= shadow_reg;
        stamp_new_reg <= 1'b1;
      end else if (dp_flush) begin
        stamp_new_reg <= 1'b0;
      end
    end
  end

  // ===========================================================
  // read mux; unmapped indices read zero
  always_comb begin
    rd_val = 8'h00;
    if (idx == `TBSPP_IDX_DATA) begin
      rd_val = rx_head;
    end else if (idx == `TBSPP_IDX_STAT) begin
      rd_val[`TBSPP_ST_MASTER] = master_s;
      rd_val[`TBSPP_ST_IRIG] = irig_seen_reg;
      rd_val[`TBSPP_ST_GPS] = gps_seen_reg;
      rd_val[`TBSPP_ST_UNUSED] = 1'b0;
      rd_val[`TBSPP_ST_TX_EMPTY] = tx_empty;
      rd_val[`TBSPP_ST_TX_FULL] = tx_full;
      rd_val[`TBSPP_ST_RX_EMPTY] = rx_empty;
      rd_val[`TBSPP_ST_OVF] = ovf_reg;
    end else if (idx == `TBSPP_IDX_PKT) begin
      rd_val[`TBSPP_PKT_STAMP] = stamp_new_reg;
      rd_val[`TBSPP_PKT_CKERR] = ckerr_reg;
    end else if ((idx >= `TBSPP_IDX_STAMP0) && (idx <= `TBSPP_IDX_STAMP7)) begin
      rd_val = stamp_reg[3'(idx - `TBSPP_IDX_STAMP0)];
    end
  end

  // ===========================================================
  // checks
  sequence s_req_waiting;
    req && avs_waitrequest_o;
  endsequence
  sequence s_one_answer;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  property p_bus_answer;
    @(posedge clk_i) disable iff (rst_i) s_req_waiting |=> s_one_answer;
  endproperty
  a_bus_answer_once: assert property (p_bus_answer) else $error("bus answer not one cycle");

  a_data_write_push: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_data && !tx_full && !tx_pop && !dp_flush) |=> tx_count == $past(tx_count) + 1'b1)
    else $error("data write did not reach transmit queue");

  a_full_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_data && tx_full && !tx_pop && !dp_flush) |=> tx_full && tx_count == $past(tx_count))
    else $error("write into full queue changed it");

  a_strobe_advance: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_strobe && !rx_push && !dp_flush) |=> rx_count == ($past(rx_empty) ? $past(rx_count)
    : $past(rx_count) - 1'b1))
    else $error("strobe did not advance receive queue correctly");

  // only a later path reset may clear the flag again
  a_overflow_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (sclk_rise && bit_cnt_reg == 3'h7 && rx_full && !dp_flush) |=>
    ovf_reg ##1 (ovf_reg || $past(dp_flush)))
    else $error("overflow flag lost");

  a_tx_master_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (!master_s) [*2] |-> link_tx_oe_n_o && !tx_pop)
    else $error("transmit driven away from master header");

  a_status_flags: assert property (@(posedge clk_i) disable iff (rst_i)
    (avs_read_i && avs_waitrequest_o && idx == `TBSPP_IDX_STAT) |=>
    avs_readdata_o[3] == $past(tx_empty) && avs_readdata_o[2] == $past(tx_full)
    && avs_readdata_o[1] == $past(rx_empty))
    else $error("status queue flags wrong");

  // data and stamp reads may carry bit 4, so only status reads are watched
  a_status_unused: assert property (@(posedge clk_i) disable iff (rst_i)
    (avs_read_i && avs_waitrequest_o && idx == `TBSPP_IDX_STAT) |=> !avs_readdata_o[4])
    else $error("unused status bit set");

  a_byte_framing: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_push |=> bit_cnt_reg == 3'h0)
    else $error("byte pushed off the eight-edge boundary");

  a_stamp_check: assert property (@(posedge clk_i) disable iff (rst_i)
    stamp_take |-> $past(state_reg, 1) != tbspp_pkg::TBSPP_IDLE ##1 stamp_new_reg)
    else $error("stamp taken without valid packet");
endmodule : tbspp_port

// file: rtl/tbspp_consts.svh
`ifndef TBSPP_CONSTS_SVH
`define TBSPP_CONSTS_SVH
// ===========================================================
// register indices, byte address is four times the index
`define TBSPP_IDX_DATA 8'h60
`define TBSPP_IDX_STAT 8'h61
`define TBSPP_IDX_STROBE 8'h62
`define TBSPP_IDX_PKT 8'h63
`define TBSPP_IDX_STAMP0 8'h64
`define TBSPP_IDX_STAMP7 8'h6B
// ===========================================================
// status and control bit positions
`define TBSPP_ST_MASTER 7
`define TBSPP_ST_IRIG 6
`define TBSPP_ST_GPS 5
`define TBSPP_ST_UNUSED 4
`define TBSPP_ST_TX_EMPTY 3
`define TBSPP_ST_TX_FULL 2
`define TBSPP_ST_RX_EMPTY 1
`define TBSPP_ST_OVF 0
`define TBSPP_PKT_STAMP 0
`define TBSPP_PKT_CKERR 1
// ===========================================================
// packet format
`define TBSPP_FRAME_START 8'h82
`define TBSPP_CMD_LOOP 8'h00
`define TBSPP_CMD_STAMP_EN 8'h01
`define TBSPP_CMD_CLK_SEL 8'h02
`define TBSPP_CMD_STAMP 8'h03
`define TBSPP_LEN_MAX 8'h3C
`define TBSPP_STAMP_MIN 8'h04
`define TBSPP_STAMP_MAX 8'h08
`define TBSPP_QUEUE_DEPTH 16
`define TBSPP_BITS_PER_BYTE 3'h7
`endif

// file: rtl/tbspp_pkg.sv
package tbspp_pkg;
  // ===========================================================
  // receive packet walker states
  typedef enum logic [5:0] {
    TBSPP_IDLE = 6'h01,
    TBSPP_CMD = 6'h02,
    TBSPP_LEN = 6'h04,
    TBSPP_DATA = 6'h08,
    TBSPP_CKL = 6'h10,
    TBSPP_CKH = 6'h20
  } tbspp_state_t;
endpackage : tbspp_pkg

// file: rtl/tbspp_sync.sv
module tbspp_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // levels
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      sync_o <= '0;
    end else begin
      meta_reg <= async_i;
      sync_o <= meta_reg;
    end
  end
endmodule : tbspp_sync

// file: rtl/tbspp_queue.sv
module tbspp_queue #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic flush_i,
  // fill side
  input wire logic push_i,
  input wire logic [WIDTH-1:0] din_i,
  output logic full_o,
  // drain side
  input wire logic pop_i,
  output logic [WIDTH-1:0] head_o,
  output logic empty_o,
  output logic [$clog2(DEPTH):0] count_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic do_push;
  logic do_pop;

  assign full_o = (count_o == (AW+1)'(DEPTH));
  assign empty_o = (count_o == '0);
  assign do_push = push_i && !full_o;
  assign do_pop = pop_i && !empty_o;
  assign head_o = mem[rd_ptr_reg];

  always_ff @(posedge clk_i) begin
    if (do_push) begin
      mem[wr_ptr_reg] <= din_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_o <= '0;
    end else if (flush_i) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_o <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_o <= count_o + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end
endmodule : tbspp_queue

// file: tb/tbspp_ctrl_model.sv
// ===========================================================
// controller side of the link: it owns clock and data
module tbspp_ctrl_model (
  // link pins
  output logic link_clk_o,
  output logic link_rx_o,
  input wire logic link_tx_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    link_clk_o = 1'b0;
    link_rx_o = 1'b0;
  end
  // clock rests low between bytes; 48 ns period inside a byte
  task automatic xfer(input logic [7:0] txb, output logic [7:0] rxb);
    for (int i = 7; i >= 0; i--) begin
      link_rx_o = txb[i];
      #24 link_clk_o = 1'b1;
      rxb[i] = link_tx_i;
      #24 link_clk_o = 1'b0;
    end
    // a stale data level must not pass for a real bit
    #24 link_rx_o = ~txb[0];
  endtask : xfer
  task automatic send_pkt(input logic [7:0] cmd, input logic [7:0] len,
                          input logic [7:0] d [8], input logic bad);
    logic [7:0] xl;
    logic [7:0] xh;
    logic [7:0] r;
    xl = cmd;
    xh = len;
    for (int i = 0; i < len; i++) begin
      if (i % 2 == 0) xl = xl ^ d[i];
      else xh = xh ^ d[i];
    end
    xfer(8'h82, r);
    xfer(cmd, r);
    xfer(len, r);
    for (int i = 0; i < len; i++) xfer(d[i], r);
    xfer(~xl ^ {7'h00, bad}, r);
    xfer(~xh, r);
  endtask : send_pkt
endmodule : tbspp_ctrl_model

// file: tb/tbspp_port_tb.sv
module tbspp_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [9:0] avs_address_i = 10'h000;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic link_clk_i;
  logic link_rx_i;
  logic link_tx_o;
  logic link_tx_oe_n_o;
  logic tx_seen;
  logic master_header_i = 1'b1;
  logic irig_pps_i = 1'b0;
  logic gps_pps_i = 1'b0;
  int n_fail = 0;
  int cmp_count = 0;
  int cyc = 0;
  tbspp_port uut (.clk_i(clk_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .link_clk_i(link_clk_i), .link_rx_i(link_rx_i),
    .link_tx_o(link_tx_o), .link_tx_oe_n_o(link_tx_oe_n_o), .master_header_i(master_header_i),
    .irig_pps_i(irig_pps_i), .gps_pps_i(gps_pps_i));
  // a released pin shows the inverse, so a stale level cannot pass for data
  assign tx_seen = link_tx_oe_n_o ? ~link_tx_o : link_tx_o;
  tbspp_ctrl_model ctrl (.link_clk_o(link_clk_i), .link_rx_o(link_rx_i),
    .link_tx_i(tx_seen));
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end
  // ===========================================================
  // shared tasks
  task automatic finish_test;
    if (n_fail == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [7:0] rd);
    @(posedge clk_i);
    avs_address_i <= {idx, 2'b00};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_writedata_i <= {24'h0, wd};
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    rd = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    bus(1'b1, idx, wd, r);
  endtask : wr
  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, r);
    check(what, r, exp);
  endtask : rd_chk
  // ===========================================================
  // scenarios
  task automatic t_reset;
    check("oe_n", {7'h0, link_tx_oe_n_o}, 8'h00);
    rd_chk(8'h61, 8'h8A, "status after reset");
    rd_chk(8'h10, 8'h00, "unmapped");
  endtask : t_reset
  task automatic t_stamp;
    ctrl.send_pkt(8'h03, 8'h04, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h0, 8'h0, 8'h0, 8'h0}, 1'b0);
    rd_chk(8'h63, 8'h01, "stamp flag");
    rd_chk(8'h64, 8'h11, "stamp lsb");
    rd_chk(8'h67, 8'h44, "stamp msb");
    rd_chk(8'h60, 8'h82, "rx head");
    wr(8'h62, 8'h5A);
    rd_chk(8'h60, 8'h03, "rx after strobe");
    ctrl.send_pkt(8'h03, 8'h08, '{8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55, 8'h55}, 1'b1);
    rd_chk(8'h63, 8'h03, "check error flag");
    rd_chk(8'h64, 8'h11, "stamp kept");
  endtask : t_stamp
  task automatic t_overflow;
    logic [7:0] r;
    wr(8'h61, 8'h01);
    rd_chk(8'h61, 8'h8A, "status after path reset");
    for (int i = 0; i < 16; i++) ctrl.xfer(8'hF0 + i[7:0], r);
    rd_chk(8'h61, 8'h88, "rx full, no overflow");
    ctrl.xfer(8'h77, r);
    rd_chk(8'h61, 8'h89, "overflow");
    for (int i = 0; i < 16; i++) begin
      rd_chk(8'h60, 8'hF0 + i[7:0], "rx order");
      wr(8'h62, 8'h00);
    end
    wr(8'h62, 8'h00);
    rd_chk(8'h61, 8'h8B, "strobe on empty");
  endtask : t_overflow
  task automatic t_tx;
    logic [7:0] r;
    wr(8'h61, 8'h00);
    for (int i = 0; i < 17; i++) wr(8'h60, 8'hA0 + i[7:0]);
    rd_chk(8'h61, 8'h86, "tx full");
    wr(8'h60, 8'hEE);
    for (int i = 0; i < 17; i++) begin
      ctrl.xfer(8'h00, r);
      check("tx byte", r, 8'hA0 + i[7:0]);
    end
    rd_chk(8'h61, 8'h89, "tx drained, extra dropped");
  endtask : t_tx
  task automatic t_cmd;
    logic [7:0] p [10];
    logic [7:0] r;
    // clock select: internal oscillator at 1 MHz, rate lsb first, then both check bytes
    p = '{8'h82, 8'h02, 8'h05, 8'h00, 8'h40, 8'h42, 8'h0F, 8'h00, 8'hBF, 8'hB5};
    for (int i = 0; i < 10; i++) wr(8'h60, p[i]);
    for (int i = 0; i < 10; i++) begin
      ctrl.xfer(8'h00, r);
      check("cmd byte", r, p[i]);
    end
  endtask : t_cmd
  task automatic t_master;
    master_header_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("oe_n off master", {7'h0, link_tx_oe_n_o}, 8'h01);
    rd_chk(8'h61, 8'h09, "status off master");
    master_header_i <= 1'b1;
  endtask : t_master
  task automatic t_pps;
    irig_pps_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    irig_pps_i <= 1'b0;
    rd_chk(8'h61, 8'hC9, "irig seen");
    gps_pps_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    gps_pps_i <= 1'b0;
    rd_chk(8'h61, 8'hE9, "gps seen");
  endtask : t_pps
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    t_reset();
    t_stamp();
    t_overflow();
    t_tx();
    t_cmd();
    t_master();
    t_pps();
    finish_test();
  end
endmodule : tbspp_port_tb
